// ---- hw/prpr_records.sv ----
/*
 Static and dynamic parameter record formatter of a wireless power receiver.
 Assumes the radio stack reads records octet by octet over the register port,
 and that measurement inputs come from logic on ref_clk.
*/
// The address map and the plain strobed port were left to the implementer.
// Operation
// - Category write accepted only for 1..5
// - Capability bits 7..3 flags, 2..0 zero
// - Maximum power byte in 100 mW steps
// - Static voltages are 16-bit millivolts
// - Resistance delta 16-bit, 0.01 ohm steps
// - Hardware, firmware revisions are maker values
// - Dynamic record is twenty octets, fixed order
// - Dynamic validity bits 7..2, 1..0 zero
// - Unflagged optional fields read as zero
// - Rectifier voltage 16-bit millivolts
// - Rectifier current 16-bit milliamperes
// - Charge port voltage, current 16-bit
// - Temperature byte offset by forty degrees
// - Dynamic voltage targets 16-bit millivolts
// - Alert byte bits 7..1, bit 0 zero
// - Charge port bit follows active output
// - Static record twenty octets, delta flag bit7
`timescale 1ns/1ps
module prpr_records
	import prpr_pkg::*;
#(
	parameter int POLL_CYCLES = POLL_CYCLES_DOC,
	parameter logic [7:0] PROTO_REV = 8'h00
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [5:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	// Measurements
	input wire logic [15:0] rectVoltage,
	input wire logic [15:0] rectCurrent,
	input wire logic [15:0] outVoltage,
	input wire logic [15:0] outCurrent,
	input wire logic [7:0] temperature,
	input wire logic [15:0] dynMinVoltage,
	input wire logic [15:0] dynSetVoltage,
	input wire logic [15:0] dynHighVoltage,
	input wire logic [7:2] measValid,
	input wire logic [7:2] alertFlags,
	input wire logic chargePortActive,
	// Status
	output logic pollLate
);
	if (POLL_CYCLES < 2 || POLL_CYCLES >= (1 << POLL_CW)) begin : g_chk
		$error("POLL_CYCLES out of range");
	end

	// Octets software may change in the static record
	function automatic logic [7:0] statMask(input logic [4:0] idx);
		logic [7:0] m;
		m = 8'hff;
		if (idx == ST_VALID) begin
			m = ST_VALID_MASK;
		end else if (idx == ST_CAPAB) begin
			m = CAPAB_MASK;
		end else if (idx == ST_PROTO || idx == 5'h02 || idx >= ST_RSV_LO) begin
			m = 8'h00;
		end
		return m;
	endfunction

	logic [7:0] statRec_r [0:REC_LEN-1];
	logic [7:0] dynSnap_r [0:REC_LEN-1];
	logic [7:0] dynLive [0:REC_LEN-1];
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic [POLL_CW-1:0] pollCnt_r;
	logic pollLate_r;
	logic snapSeen_r;

	wire [4:0] idx = addr[4:0];
	wire inStat = (addr[5] == 1'b0) && (idx < 5'd20);
	wire inDyn = (addr[5] == 1'b1) && (idx < 5'd20);
	wire snapTake = rdStb && (addr == DYN_BASE);
	wire catLegal = (wrData >= CAT_MIN) && (wrData <= CAT_MAX);
	wire statWr = wrStb && inStat && ((idx != ST_CATEGORY) || catLegal);
	wire [7:0] mask = statMask(idx);
	wire deltaOk = statRec_r[ST_VALID][ST_DELTA_VALID_BIT];

	// Static record storage
	// Revisions stored as written
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < REC_LEN; i++) begin
				statRec_r[i] <= 8'h00;
			end
			statRec_r[ST_CATEGORY] <= CAT_RESET;
			statRec_r[ST_PROTO] <= PROTO_REV;
		end else if (statWr) begin
			statRec_r[idx] <= (statRec_r[idx] & ~mask) | (wrData & mask);
		end
	end

	assign dynLive[DY_VALID] = {measValid, 2'b00};
	assign dynLive[DY_VRECT] = rectVoltage[7:0];
	assign dynLive[DY_VRECT+1] = rectVoltage[15:8];
	assign dynLive[DY_IRECT] = rectCurrent[7:0];
	assign dynLive[DY_IRECT+1] = rectCurrent[15:8];
	// Optional fields zeroed unless valid
	assign dynLive[DY_VOUT] = measValid[VB_VOUT] ? outVoltage[7:0] : 8'h00;
	assign dynLive[DY_VOUT+1] = measValid[VB_VOUT] ? outVoltage[15:8] : 8'h00;
	assign dynLive[DY_IOUT] = measValid[VB_IOUT] ? outCurrent[7:0] : 8'h00;
	assign dynLive[DY_IOUT+1] = measValid[VB_IOUT] ? outCurrent[15:8] : 8'h00;
	assign dynLive[DY_TEMP] = measValid[VB_TEMP] ? temperature : 8'h00;
	assign dynLive[DY_VMIN] = measValid[VB_VMIN] ? dynMinVoltage[7:0] : 8'h00;
	assign dynLive[DY_VMIN+1] = measValid[VB_VMIN] ? dynMinVoltage[15:8] : 8'h00;
	assign dynLive[DY_VSET] = measValid[VB_VSET] ? dynSetVoltage[7:0] : 8'h00;
	assign dynLive[DY_VSET+1] = measValid[VB_VSET] ? dynSetVoltage[15:8] : 8'h00;
	assign dynLive[DY_VHIGH] = measValid[VB_VHIGH] ? dynHighVoltage[7:0] : 8'h00;
	assign dynLive[DY_VHIGH+1] = measValid[VB_VHIGH] ? dynHighVoltage[15:8] : 8'h00;
	// Charge port bit from live output
	assign dynLive[DY_ALERT] = {alertFlags, chargePortActive, 1'b0};
	assign dynLive[DY_RSV_LO] = 8'h00;
	assign dynLive[DY_RSV_LO+1] = 8'h00;
	assign dynLive[DY_RSV_LO+2] = 8'h00;

	// Snapshot on the first octet keeps a multi-octet read coherent
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < REC_LEN; i++) begin
				dynSnap_r[i] <= 8'h00;
			end
		end else if (snapTake) begin
			for (int i = 0; i < REC_LEN; i++) begin
				dynSnap_r[i] <= dynLive[i];
			end
		end
	end

	// Watch for an overdue record read
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pollCnt_r <= '0;
			pollLate_r <= 1'b0;
			snapSeen_r <= 1'b0;
		end else if (snapTake) begin
			pollCnt_r <= '0;
			pollLate_r <= 1'b0;
			snapSeen_r <= 1'b1;
		end else if (pollCnt_r == POLL_CW'(POLL_CYCLES - 1)) begin
			pollLate_r <= 1'b1;
		end else begin
			pollCnt_r <= pollCnt_r + POLL_CW'(1);
		end
	end

	wire deltaOct = (idx == ST_DELTA) || (idx == ST_DELTA + 5'd1);
	wire [7:0] statByte = (deltaOct && !deltaOk) ? 8'h00 : statRec_r[idx];
	// Octet zero answered live, rest from snapshot
	wire [7:0] dynByte = (idx == DY_VALID) ? dynLive[DY_VALID] : dynSnap_r[idx];
	wire [7:0] statusByte = {6'b0, snapSeen_r, pollLate_r};

	// Unmapped addresses read as zero
	always_comb begin
		rdData_nxt = 8'h00;
		if (rdStb) begin
			if (inStat) begin
				rdData_nxt = statByte;
			end else if (inDyn) begin
				rdData_nxt = dynByte;
			end else if (addr == STATUS_ADDR) begin
				rdData_nxt = statusByte;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_r <= 8'h00;
		end else begin
			rdData_r <= rdData_nxt;
		end
	end

	assign rdData = rdData_r;
	assign pollLate = pollLate_r;

	property p_cat_legal;
		@(posedge ref_clk) disable iff (!rst_n)
		rdStb && addr == STAT_BASE + 6'(ST_CATEGORY) |=> rdData >= CAT_MIN && rdData <= CAT_MAX;
	endproperty
	a_cat_legal: assert property (p_cat_legal) else $error("category out of range");

	property p_cap_rsv;
		@(posedge ref_clk) disable iff (!rst_n)
		rdStb && addr == STAT_BASE + 6'(ST_CAPAB) |=> rdData[2:0] == 3'b000;
	endproperty
	a_cap_rsv: assert property (p_cap_rsv) else $error("capability reserved bits set");

	property p_maxpow;
		@(posedge ref_clk) disable iff (!rst_n)
		wrStb && addr == STAT_BASE + 6'(ST_MAXPOW) ##1 rdStb && addr == STAT_BASE + 6'(ST_MAXPOW)
			|=> rdData == $past(wrData, 2);
	endproperty
	a_maxpow: assert property (p_maxpow) else $error("max power readback wrong");

	property p_vmin;
		@(posedge ref_clk) disable iff (!rst_n)
		wrStb && addr == STAT_BASE + 6'(ST_VMIN) ##1 rdStb && addr == STAT_BASE + 6'(ST_VMIN)
			|=> rdData == $past(wrData, 2);
	endproperty
	a_vmin: assert property (p_vmin) else $error("static voltage readback wrong");

	property p_delta_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		rdStb && addr == STAT_BASE + 6'(ST_DELTA) && !deltaOk |=> rdData == 8'h00;
	endproperty
	a_delta_zero: assert property (p_delta_zero) else $error("unflagged delta not zero");

	property p_vrect_lsb;
		@(posedge ref_clk) disable iff (!rst_n)
		snapTake ##1 rdStb && addr == DYN_BASE + 6'(DY_VRECT) && !snapTake
			|=> rdData == $past(rectVoltage[7:0], 2);
	endproperty
	a_vrect_lsb: assert property (p_vrect_lsb) else $error("rectifier voltage low octet");

	property p_port_bit;
		@(posedge ref_clk) disable iff (!rst_n)
		snapTake |=> dynSnap_r[DY_ALERT][AB_PORT] == $past(chargePortActive)
			&& dynSnap_r[DY_ALERT][0] == 1'b0;
	endproperty
	a_port_bit: assert property (p_port_bit) else $error("charge port bit wrong");

	property p_valid_rsv;
		@(posedge ref_clk) disable iff (!rst_n)
		rdStb && addr == DYN_BASE |=> rdData[1:0] == 2'b00 && rdData[7:2] == $past(measValid);
	endproperty
	a_valid_rsv: assert property (p_valid_rsv) else $error("dynamic validity byte wrong");

	property p_dyn_rsv;
		@(posedge ref_clk) disable iff (!rst_n)
		rdStb && inDyn && idx >= DY_RSV_LO |=> rdData == 8'h00;
	endproperty
	a_dyn_rsv: assert property (p_dyn_rsv) else $error("dynamic reserved octet nonzero");

	property p_late;
		@(posedge ref_clk) disable iff (!rst_n)
		snapTake |=> !pollLate ##1 !pollLate;
	endproperty
	a_late: assert property (p_late) else $error("late flag right after read");

	property p_rd_idle;
		@(posedge ref_clk) disable iff (!rst_n)
		!rdStb |=> rdData == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule

// ---- common/prpr_pkg.sv ----
/*
 Shared constants for the power receiver parameter record block.
 Assumes one 100 MHz clock and an 8-bit register port.
*/
package prpr_pkg;
	// Port address map
	localparam logic [5:0] STAT_BASE = 6'h00;
	localparam logic [5:0] DYN_BASE = 6'h20;
	localparam logic [5:0] STATUS_ADDR = 6'h3f;
	localparam int REC_LEN = 20;

	// Static record octets
	localparam logic [4:0] ST_VALID = 5'h00;
	localparam logic [4:0] ST_PROTO = 5'h01;
	localparam logic [4:0] ST_CATEGORY = 5'h03;
	localparam logic [4:0] ST_CAPAB = 5'h04;
	localparam logic [4:0] ST_HWREV = 5'h05;
	localparam logic [4:0] ST_FWREV = 5'h06;
	localparam logic [4:0] ST_MAXPOW = 5'h07;
	localparam logic [4:0] ST_VMIN = 5'h08;
	localparam logic [4:0] ST_DELTA = 5'h0e;
	localparam logic [4:0] ST_RSV_LO = 5'h10;

	// Static field layout and reset values
	localparam int ST_DELTA_VALID_BIT = 7;
	localparam logic [7:0] ST_VALID_MASK = 8'h80;
	localparam logic [7:0] CAPAB_MASK = 8'hf8;
	localparam logic [7:0] CAT_MIN = 8'h01;
	localparam logic [7:0] CAT_MAX = 8'h05;
	localparam logic [7:0] CAT_RESET = 8'h01;

	// Dynamic record octets
	localparam logic [4:0] DY_VALID = 5'h00;
	localparam logic [4:0] DY_VRECT = 5'h01;
	localparam logic [4:0] DY_IRECT = 5'h03;
	localparam logic [4:0] DY_VOUT = 5'h05;
	localparam logic [4:0] DY_IOUT = 5'h07;
	localparam logic [4:0] DY_TEMP = 5'h09;
	localparam logic [4:0] DY_VMIN = 5'h0a;
	localparam logic [4:0] DY_VSET = 5'h0c;
	localparam logic [4:0] DY_VHIGH = 5'h0e;
	localparam logic [4:0] DY_ALERT = 5'h10;
	localparam logic [4:0] DY_RSV_LO = 5'h11;

	// Dynamic validity and alert bits
	localparam int VB_VOUT = 7;
	localparam int VB_IOUT = 6;
	localparam int VB_TEMP = 5;
	localparam int VB_VMIN = 4;
	localparam int VB_VSET = 3;
	localparam int VB_VHIGH = 2;
	localparam int AB_PORT = 1;

	// Status register bits
	localparam int SB_LATE = 0;
	localparam int SB_SNAP = 1;

	// Poll supervision time
	localparam int CLK_MHZ = 100;
	localparam int POLL_TIME_MS = 250;
	localparam int POLL_CYCLES_DOC = POLL_TIME_MS * CLK_MHZ * 1000;
	localparam int POLL_CW = 25;
endpackage

// ---- test/prpr_reader.sv ----
/*
 Transmitter-side reader model: drives the register port as the radio link would.
 Assumes one clock shared with the receiver block; the slave never stalls.
 Every call starts just after a rising edge and returns on one.
*/
`timescale 1ns/1ps
module prpr_reader (
	// Clock
	input wire logic ref_clk,
	// Register port
	output logic [5:0] addr,
	output logic [7:0] wrData,
	output logic wrStb,
	output logic rdStb,
	input wire logic [7:0] rdData
);
	initial begin
		addr = 6'h00;
		wrData = 8'h00;
		wrStb = 1'b0;
		rdStb = 1'b0;
	end
	// Write strobe stays up on return; the next call replaces it, so a read follows with no gap
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		rdStb <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Octet record reads
	// Caller assembles fields low octet first and keeps its own table
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		addr <= a;
		wrStb <= 1'b0;
		rdStb <= 1'b1;
		@(posedge ref_clk);
		rdStb <= 1'b0;
		@(posedge ref_clk);
		d = rdData;
	endtask
	// Two reads on consecutive cycles, each answer taken one edge after the edge that ends its slot
	task automatic rd2(input logic [5:0] a0, input logic [5:0] a1, output logic [7:0] d0,
		output logic [7:0] d1);
		addr <= a0;
		wrStb <= 1'b0;
		rdStb <= 1'b1;
		@(posedge ref_clk);
		addr <= a1;
		@(posedge ref_clk);
		d0 = rdData;
		rdStb <= 1'b0;
		@(posedge ref_clk);
		d1 = rdData;
	endtask
endmodule

// ---- test/prpr_records_tb.sv ----
/*
 Self-checking bench for the parameter record block.
 Assumes the reader model issues all port traffic; poll time is shortened.
*/
`timescale 1ns/1ps
module prpr_records_tb;
	import prpr_pkg::*;
	localparam int POLL = 50;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] addr;
	logic [7:0] wrData, rdData, got, temperature, ex;
	logic wrStb, rdStb, chargePortActive, pollLate;
	logic [15:0] rectVoltage, rectCurrent, outVoltage, outCurrent;
	logic [15:0] dynMinVoltage, dynSetVoltage, dynHighVoltage;
	logic [7:2] measValid, alertFlags;
	logic [159:0] rec;
	logic [31:0] r;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int seed = 28406;
	always #5 ref_clk = ~ref_clk;
	prpr_reader u_prpr_reader (.ref_clk(ref_clk), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
	prpr_records #(.POLL_CYCLES(POLL)) u_prpr_records (.ref_clk(ref_clk), .rst_n(rst_n),
		.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.rectVoltage(rectVoltage), .rectCurrent(rectCurrent), .outVoltage(outVoltage),
		.outCurrent(outCurrent), .temperature(temperature), .dynMinVoltage(dynMinVoltage),
		.dynSetVoltage(dynSetVoltage), .dynHighVoltage(dynHighVoltage),
		.measValid(measValid), .alertFlags(alertFlags),
		.chargePortActive(chargePortActive), .pollLate(pollLate));
	// Expected dynamic record from the live inputs, optional fields masked
	function automatic logic [159:0] dyn_rec();
		logic [7:0] v;
		v = {measValid, 2'b00};
		return {24'h000000, alertFlags, chargePortActive, 1'b0,
			dynHighVoltage & {16{v[2]}}, dynSetVoltage & {16{v[3]}},
			dynMinVoltage & {16{v[4]}}, temperature & {8{v[5]}},
			outCurrent & {16{v[6]}}, outVoltage & {16{v[7]}}, rectCurrent, rectVoltage, v};
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	task automatic rc(input string nm, input logic [5:0] a, input logic [7:0] e);
		u_prpr_reader.rd(a, got);
		chk(nm, e, got);
	endtask
	// First two passes force all-invalid and all-valid corners
	task automatic rnd(input int k);
		@(posedge ref_clk);
		r = $random(seed);
		{rectVoltage, rectCurrent} <= r;
		r = $random(seed);
		{outVoltage, outCurrent} <= r;
		r = $random(seed);
		{dynMinVoltage, dynSetVoltage} <= r;
		r = $random(seed);
		{dynHighVoltage, temperature} <= r[23:0];
		measValid <= (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : r[29:24];
		alertFlags <= r[5:0] ^ r[31:26];
		chargePortActive <= r[30];
	endtask
	task automatic test_done();
		$display("Checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		{rectVoltage, rectCurrent, outVoltage, outCurrent, dynMinVoltage, dynSetVoltage,
			dynHighVoltage, temperature, measValid, alertFlags, chargePortActive} = '0;
		repeat (3) @(posedge ref_clk);
		chk("reset late", 8'h00, {7'h00, pollLate});
		rst_n <= 1'b1;
		rc("category", 6'h03, CAT_RESET);
		rc("st valid", 6'h00, 8'h00);
		u_prpr_reader.wr(6'h01, 8'h5a);
		rc("proto", 6'h01, 8'h00);
		ex = CAT_RESET;
		for (int c = 0; c < 8; c++) begin
			u_prpr_reader.wr(6'h03, 8'(c));
			ex = (c >= 1 && c <= 5) ? 8'(c) : ex;
			rc("category", 6'h03, ex);
		end
		$display("static reset and category done");
		for (int k = 0; k < 3; k++) begin
			for (int a = 4; a < 14; a++) begin
				r = $random(seed);
				u_prpr_reader.wr(6'(a), r[7:0]);
				ex = (a == 4) ? r[7:0] & CAPAB_MASK : r[7:0];
				rc("static octet", 6'(a), ex);
			end
		end
		u_prpr_reader.wr(6'h00, 8'hff);
		u_prpr_reader.wr(6'h0e, 8'h34);
		u_prpr_reader.wr(6'h0f, 8'h12);
		rc("st valid", 6'h00, ST_VALID_MASK);
		rc("delta lo", 6'h0e, 8'h34);
		rc("delta hi", 6'h0f, 8'h12);
		u_prpr_reader.wr(6'h00, 8'h7f);
		rc("delta off", 6'h0e, 8'h00);
		rc("reserved", 6'h10, 8'h00);
		rc("unmapped", 6'h15, 8'h00);
		$display("static fields done");
		for (int k = 0; k < 6; k++) begin
			rnd(k);
			@(posedge ref_clk);
			rec = dyn_rec();
			u_prpr_reader.rd2(DYN_BASE, DYN_BASE + 6'h01, got, ex);
			chk("dyn validity", rec[7:0], got);
			chk("dyn octet", rec[15:8], ex);
			rnd(k + 2);
			for (int i = 2; i < REC_LEN; i++) begin
				ex = rec[i*8 +: 8];
				rc("dyn octet", DYN_BASE + 6'(i), ex);
			end
		end
		$display("dynamic record done");
		u_prpr_reader.rd(DYN_BASE, got);
		repeat (POLL + 5) @(posedge ref_clk);
		chk("poll late", 8'h01, {7'h00, pollLate});
		rc("status", STATUS_ADDR, 8'h03);
		u_prpr_reader.rd(DYN_BASE, got);
		chk("poll clear", 8'h00, {7'h00, pollLate});
		repeat (POLL - 5) @(posedge ref_clk);
		chk("poll early", 8'h00, {7'h00, pollLate});
		$display("poll supervision done");
		test_done();
	end
endmodule
